// ===== ext_irq_cfg.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * external interrupt controller.
 * Assumes byte addressing with registers packed into aligned 32-bit words.
 */
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH

// byte offsets of the registers
`define OFS_CONTROL        8'h00
`define OFS_SYNC_STATUS    8'h01
`define OFS_NMI_CONTROL    8'h02
`define OFS_NMI_FLAG       8'h03
`define OFS_EVENT_CTRL     8'h04
`define OFS_IRQ_EN_CLEAR   8'h08
`define OFS_IRQ_EN_SET     8'h0c
`define OFS_IRQ_FLAGS      8'h10
`define OFS_WAKE_ENABLES   8'h14
`define OFS_PIN_CFG_LOW    8'h18
`define OFS_PIN_CFG_HIGH   8'h1c

// field positions
`define BIT_SOFT_RESET     0
`define BIT_ENABLE         1
`define BIT_SYNC_PENDING   7
`define BIT_NMI_FILTER     3
`define BIT_NMI_FLAG       0

// reset values
`define RST_BYTE           8'h00
`define RST_HALF           16'h0000
`define RST_WORD           32'h0000_0000

// cycles taken by a synchronised control write
`define SYNC_CYCLES        4'h4

`endif

// ===== ext_irq_pkg.sv
/*
 * Types of the external interrupt controller.
 * Assumes ext_irq_cfg.svh for the numeric constants.
 */
package ext_irq_pkg;

   // sense selection codes
   typedef enum logic [2:0] {
      SENSE_NONE = 3'h0,
      SENSE_RISE = 3'h1,
      SENSE_FALL = 3'h2,
      SENSE_BOTH = 3'h3,
      SENSE_HIGH = 3'h4,
      SENSE_LOW  = 3'h5
   } sense_t;

   // control synchronisation states, one-hot
   typedef enum logic [2:0] {
      SYNC_IDLE  = 3'b001,
      SYNC_EN    = 3'b010,
      SYNC_RST   = 3'b100
   } sync_state_t;

   // whole controller state
   typedef struct packed {
      sync_state_t  sync_st;
      logic [3:0]   sync_cnt;
      logic         enable;
      logic         soft_reset;
      logic         active;
      logic [3:0]   nmi_ctrl;
      logic         nmi_flag;
      logic [15:0]  event_ctrl;
      logic [15:0]  irq_en;
      logic [15:0]  flags;
      logic [15:0]  wake_en;
      logic [31:0]  cfg_low;
      logic [31:0]  cfg_high;
      logic [15:0]  event_pulse;
      logic [31:0]  rdata;
   } ctl_state_t;

   // per-pin detector state
   typedef struct packed {
      logic [2:0]   samples;
      logic         prev;
   } det_state_t;

endpackage

// ===== pin_detect.sv
/*
 * Sense detector for one interrupt pin: optional three-sample majority
 * filter and edge or level match.
 * Assumes the pin is synchronous to clock_in.
 */
`timescale 1ns/1ps
module pin_detect
   import ext_irq_pkg::*;
(
   // clock and reset
   input  wire logic       clock_in,
   input  wire logic       nrst_in,
   // pin and its configuration
   input  wire logic       pin_in,
   input  wire logic [2:0] sense_in,
   input  wire logic       filter_en_in,
   // detection
   output logic            hit_out
);
   det_state_t st_r;
   det_state_t st_nxt;
   logic       maj;
   logic       val;

   // majority of the three samples, unfiltered pins pass straight
   assign maj = (st_r.samples[0] & st_r.samples[1]) | (st_r.samples[0] & st_r.samples[2])
              | (st_r.samples[1] & st_r.samples[2]);  // [RULE18]
   assign val = filter_en_in ? maj : pin_in;

   // sample shift and previous value for edges
   always_comb begin
      st_nxt         = st_r;
      st_nxt.samples = {st_r.samples[1:0], pin_in};
      st_nxt.prev    = val;
   end

   // sense decode
   always_comb begin
      case (sense_in)
         SENSE_RISE: hit_out = val & ~st_r.prev;  // [RULE15]
         SENSE_FALL: hit_out = ~val & st_r.prev;
         SENSE_BOTH: hit_out = val ^ st_r.prev;
         SENSE_HIGH: hit_out = val;
         SENSE_LOW:  hit_out = ~val;
         default:    hit_out = 1'b0;              // none and reserved codes
      endcase
   end

   // state register
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule

// ===== external_irq_sync_wake.sv
/*
 * External interrupt controller: register file, synchronised enable and
 * soft reset with bus stall, flags, interrupt lines, events and wake-up.
 * Assumes a master that holds a write while ready_out is low.
 */
// What this block does
// [RULE1] asleep, a matching pin with wake enable set wakes the system
// [RULE2] wake-up also needs that pin's interrupt enable set
// [RULE3] software should not set wake enable with interrupt enable clear
// [RULE4] sync pending sets at once, clears when synchronisation ends; status at 0x01
// [RULE5] a further synchronised write while pending stalls the bus, then completes
// [RULE6] soft reset and enable writes are the synchronised operations
// [RULE7] 8, 16 and 32 bit accesses are supported atomically
// [RULE8] every byte and half of a word register is addressable alone
// [RULE9] enable-protected registers ignore writes while enabled
// [RULE10] control at 0x00, enable bit 1 turns controller on after a delay
// [RULE11] written enable reads back at once while sync pending is set
// [RULE12] soft reset bit 0 returns all registers to reset, controller disabled
// [RULE13] a write setting soft reset discards all its other bits
// [RULE14] soft reset reads one until done, then clears with sync pending
// [RULE15] sense codes: none, rise, fall, both, high, low; 6 and 7 reserved
// [RULE16] the non-maskable flag clears by writing one, zero leaves it
// [RULE17] a request line is high while flag and enable are both set
// [RULE18] a filtered pin gives the majority of three samples
// [RULE19] the stall withholds ready until synchronisation ends
// [RULE20] pin config: eight four-bit fields, filter bit above three sense bits
`timescale 1ns/1ps
`include "ext_irq_cfg.svh"
module external_irq_sync_wake
   import ext_irq_pkg::*;
#(
   parameter logic [3:0] SYNC_CYCLES = `SYNC_CYCLES
)
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        nrst_in,
   // register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [1:0]  size_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   output logic             ready_out,
   // pins
   input  wire logic [15:0] ext_irq_pin_in,
   input  wire logic        nmi_pin_in,
   input  wire logic        sleeping_in,
   // requests, events and wake
   output logic [15:0]      irq_out,
   output logic             nmi_irq_out,
   output logic [15:0]      event_out,
   output logic             wake_out
);
   ctl_state_t  st_r;
   ctl_state_t  st_nxt;
   ctl_state_t  st_rst;
   logic [15:0] hit;
   logic        nmi_hit;
   logic [3:0]  be;
   logic [2:0]  word;
   logic        mapped;
   logic        ctrl_wr;
   logic        wr_take;
   logic        rd_take;
   logic        locked;
   logic [31:0] word0;

   // merge written byte lanes into an old value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  lanes);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (lanes[i]) begin
            res[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return res;
   endfunction

   // one detector per pin, fields from the two config words
   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_pin
         logic [3:0] field;
         assign field = (g < 8) ? st_r.cfg_low[4*(g%8) +: 4]
                                : st_r.cfg_high[4*(g%8) +: 4];  // [RULE20]
         pin_detect u_det (
            .clock_in     (clock_in),
            .nrst_in      (nrst_in),
            .pin_in       (ext_irq_pin_in[g]),
            .sense_in     (field[2:0]),
            .filter_en_in (field[3]),
            .hit_out      (hit[g])
         );
      end
   endgenerate

   // non-maskable pin detector, works without the controller enabled
   pin_detect u_nmi_det (
      .clock_in     (clock_in),
      .nrst_in      (nrst_in),
      .pin_in       (nmi_pin_in),
      .sense_in     (st_r.nmi_ctrl[2:0]),
      .filter_en_in (st_r.nmi_ctrl[`BIT_NMI_FILTER]),
      .hit_out      (nmi_hit)
   );

   // byte lanes from size and low address bits
   always_comb begin
      case (size_in)
         2'h0:    be = 4'h1 << addr_in[1:0];                          // [RULE7]
         2'h1:    be = addr_in[0] ? 4'h0 : (addr_in[1] ? 4'hc : 4'h3); // [RULE8]
         2'h2:    be = (addr_in[1:0] == 2'h0) ? 4'hf : 4'h0;
         default: be = 4'h0;
      endcase
   end

   // decode and stall
   assign word    = addr_in[4:2];
   assign mapped  = (addr_in[7:5] == 3'h0) && (be != 4'h0);
   assign ctrl_wr = wr_in && mapped && (word == 3'h0) && be[0];
   assign ready_out = !(ctrl_wr && (st_r.sync_st != SYNC_IDLE));  // [RULE5] [RULE19]
   assign wr_take = wr_in && mapped && ready_out;
   assign rd_take = rd_in && mapped;
   assign locked  = st_r.enable | st_r.active;

   // first word: control, status, nmi control, nmi flag
   assign word0 = {7'h0, st_r.nmi_flag, 4'h0, st_r.nmi_ctrl,
                   st_r.sync_st != SYNC_IDLE, 7'h0,
                   6'h0, st_r.enable, st_r.soft_reset};  // [RULE4] [RULE11] [RULE14]

   // reset image of the state
   always_comb begin
      st_rst         = '0;
      st_rst.sync_st = SYNC_IDLE;
      st_rst.rdata   = `RST_WORD;
   end

   // next state
   always_comb begin
      st_nxt             = st_r;
      st_nxt.rdata       = `RST_WORD;
      st_nxt.event_pulse = hit & st_r.event_ctrl & {16{st_r.active}};
      // register writes
      if (wr_take) begin
         if (ctrl_wr && wdata_in[`BIT_SOFT_RESET]) begin
            st_nxt.soft_reset = 1'b1;                    // [RULE12] [RULE13]
            st_nxt.sync_st    = SYNC_RST;                // [RULE6]
            st_nxt.sync_cnt   = SYNC_CYCLES;
         end else begin
            case (word)
               3'h0: begin
                  if (be[0]) begin
                     st_nxt.enable   = wdata_in[`BIT_ENABLE];  // [RULE10] [RULE11]
                     st_nxt.sync_st  = SYNC_EN;                // [RULE4] [RULE6]
                     st_nxt.sync_cnt = SYNC_CYCLES;
                  end
                  if (be[2]) begin
                     st_nxt.nmi_ctrl = wdata_in[19:16];
                  end
                  if (be[3] && wdata_in[24 + `BIT_NMI_FLAG]) begin
                     st_nxt.nmi_flag = 1'b0;                   // [RULE16]
                  end
               end
               3'h1: begin
                  if (!locked) begin
                     st_nxt.event_ctrl = 16'(merge({16'h0, st_r.event_ctrl}, wdata_in, be));  // [RULE9]
                  end
               end
               3'h2: st_nxt.irq_en = st_r.irq_en & ~(wdata_in[15:0] & {{8{be[1]}}, {8{be[0]}}});
               3'h3: st_nxt.irq_en = st_r.irq_en | (wdata_in[15:0] & {{8{be[1]}}, {8{be[0]}}});
               3'h4: st_nxt.flags  = st_r.flags & ~(wdata_in[15:0] & {{8{be[1]}}, {8{be[0]}}});
               3'h5: begin
                  if (!locked) begin
                     st_nxt.wake_en = 16'(merge({16'h0, st_r.wake_en}, wdata_in, be));  // [RULE9]
                  end
               end
               3'h6: begin
                  if (!locked) begin
                     st_nxt.cfg_low = merge(st_r.cfg_low, wdata_in, be);  // [RULE9]
                  end
               end
               3'h7: begin
                  if (!locked) begin
                     st_nxt.cfg_high = merge(st_r.cfg_high, wdata_in, be);  // [RULE9]
                  end
               end
               default: st_nxt.rdata = `RST_WORD;
            endcase
         end
      end
      // hardware sets win over software clears
      st_nxt.flags    = st_nxt.flags | (hit & {16{st_r.active}});
      st_nxt.nmi_flag = st_nxt.nmi_flag | nmi_hit;
      // read data, unselected lanes zero
      if (rd_take) begin
         case (word)
            3'h0:    st_nxt.rdata = word0;
            3'h1:    st_nxt.rdata = {16'h0, st_r.event_ctrl};
            3'h2:    st_nxt.rdata = {16'h0, st_r.irq_en};
            3'h3:    st_nxt.rdata = {16'h0, st_r.irq_en};
            3'h4:    st_nxt.rdata = {16'h0, st_r.flags};
            3'h5:    st_nxt.rdata = {16'h0, st_r.wake_en};
            3'h6:    st_nxt.rdata = st_r.cfg_low;
            3'h7:    st_nxt.rdata = st_r.cfg_high;
            default: st_nxt.rdata = `RST_WORD;
         endcase
         st_nxt.rdata = st_nxt.rdata & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      end
      // synchronisation countdown
      case (st_r.sync_st)
         SYNC_IDLE: begin
         end
         SYNC_EN: begin
            if (st_r.sync_cnt <= 4'h1) begin
               st_nxt.active  = st_nxt.enable;  // [RULE10]
               st_nxt.sync_st = SYNC_IDLE;      // [RULE4]
            end else begin
               st_nxt.sync_cnt = st_r.sync_cnt - 4'h1;
            end
         end
         SYNC_RST: begin
            if (st_r.sync_cnt <= 4'h1) begin
               st_nxt = st_rst;                 // [RULE12] [RULE14]
            end else begin
               st_nxt.sync_cnt = st_r.sync_cnt - 4'h1;
            end
         end
         default: st_nxt.sync_st = SYNC_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         st_r <= '{sync_st: SYNC_IDLE, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs
   assign rdata_out   = st_r.rdata;
   assign irq_out     = st_r.flags & st_r.irq_en;  // [RULE17]
   assign nmi_irq_out = st_r.nmi_flag;
   assign event_out   = st_r.event_pulse;
   // wake needs match, wake enable and interrupt enable
   assign wake_out    = sleeping_in && st_r.active
                        && |(hit & st_r.wake_en & st_r.irq_en);  // [RULE1] [RULE2]
endmodule

// ===== ext_irq_asserts.sv
/* Checker of the register port, stall, request and wake outputs.
   Assumes it is bound into external_irq_sync_wake. */
`timescale 1ns/1ps
module ext_irq_asserts #(
   parameter logic [3:0] SYNC_CYCLES = 4'h4
)(
   // clock and reset
   input wire logic        clock_in,
   input wire logic        nrst_in,
   // register port
   input wire logic [7:0]  addr_in,
   input wire logic [1:0]  size_in,
   input wire logic [31:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic        ready_out,
   // requests and wake
   input wire logic [15:0] irq_out,
   input wire logic        sleeping_in,
   input wire logic        wake_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!nrst_in);

   // accepted byte write to the control register
   wire logic ctl_wr;
   wire logic en_clr;
   assign ctl_wr = wr_in && ready_out && addr_in == 8'h00 && size_in == 2'h0;
   assign en_clr = wr_in && addr_in == 8'h08 && size_in == 2'h2 && wdata_in[15:0] == 16'hffff;

   property p_stall_cause;
      !ready_out |-> wr_in && addr_in == 8'h00;
   endproperty
   a_stall_cause: assert property (p_stall_cause) else $error("stall without control write");
   property p_stall_bound;
      wr_in && !ready_out |-> ##[1:8] ready_out;
   endproperty
   a_stall_bound: assert property (p_stall_bound) else $error("stall too long");
   property p_pend;
      ctl_wr && wdata_in[1:0] == 2'b10 ##2 rd_in && addr_in == 8'h00 && size_in == 2'h2
         |=> rdata_out[15:0] == 16'h8002;
   endproperty
   a_pend: assert property (p_pend) else $error("enable readback or pending wrong");
   property p_soft_reset;
      ctl_wr && wdata_in[0] ##2 rd_in && addr_in == 8'h00 && size_in == 2'h2
         |=> rdata_out[15] && rdata_out[0] && rdata_out[14:8] == 7'h00;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset readback wrong");
   property p_irq_clr;
      en_clr |=> irq_out == 16'h0000;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("request stays after disable");
   property p_wake_sleep;
      wake_out |-> sleeping_in;
   endproperty
   a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
   property p_wake_clr;
      en_clr |=> !wake_out;
   endproperty
   a_wake_clr: assert property (p_wake_clr) else $error("wake without enable");
   property p_rdata_idle;
      !$past(rd_in) |-> rdata_out == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
   property p_unmapped;
      rd_in && addr_in[7:5] != 3'h0 |=> rdata_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// ===== ext_irq_host.sv
/* Processor model that masters the register port.
   Assumes the slave stalls writes only through ready_in. */
`timescale 1ns/1ps
module ext_irq_host (
   // clock and answer
   input  wire logic        clock_in,
   input  wire logic        ready_in,
   input  wire logic [31:0] rdata_in,
   // request
   output logic [7:0]       addr_out,
   output logic [1:0]       size_out,
   output logic [31:0]      wdata_out,
   output logic             wr_out,
   output logic             rd_out
);
   // idle bus at time zero
   initial begin
      addr_out = 8'h00;
      size_out = 2'h0;
      wdata_out = 32'h0;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end

   // write held until taken, bounded
   task automatic wr_reg(input logic [7:0] a, input logic [1:0] s, input logic [31:0] d,
                         output bit ok);
      int n;
      n = 0;
      @(posedge clock_in);
      addr_out <= a;
      size_out <= s;
      wdata_out <= d;
      wr_out <= 1'b1;
      do begin
         @(negedge clock_in);
         n++;
      end while (!ready_in && n < 20);
      ok = ready_in;
      @(posedge clock_in);
      wr_out <= 1'b0;
   endtask

   // one-cycle read, data taken in the following cycle
   task automatic rd_reg(input logic [7:0] a, input logic [1:0] s, output logic [31:0] d);
      @(posedge clock_in);
      addr_out <= a;
      size_out <= s;
      rd_out <= 1'b1;
      @(posedge clock_in);
      rd_out <= 1'b0;
      @(negedge clock_in);
      d = rdata_in;
   endtask
endmodule

// ===== tb_external_irq_sync_wake.sv
/* Self-checking bench of the external interrupt controller.
   Assumes ext_irq_host as bus master and ext_irq_asserts bound in. */
`timescale 1ns/1ps
module tb_external_irq_sync_wake;
   logic        clock_in, nrst_in, sleeping_in, nmi_pin_in, wr, rd, ready, nmi_irq, wake;
   logic [15:0] pins, irq_out, event_out;
   logic [31:0] wdata, rdata, rnd, v;
   logic [7:0]  addr;
   logic [1:0]  size;
   logic [3:0]  got;
   int          n_mismatch, tests_run;
   bit          ok;

   external_irq_sync_wake #(.SYNC_CYCLES(4'h4)) i_external_irq_sync_wake (
      .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr), .size_in(size),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ready_out(ready),
      .ext_irq_pin_in(pins), .nmi_pin_in(nmi_pin_in), .sleeping_in(sleeping_in),
      .irq_out(irq_out), .nmi_irq_out(nmi_irq), .event_out(event_out), .wake_out(wake));
   ext_irq_host i_ext_irq_host (.clock_in(clock_in), .ready_in(ready), .rdata_in(rdata),
      .addr_out(addr), .size_out(size), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

   // 125 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end

   // compare, report and close
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic w(input logic [7:0] a, input logic [1:0] s, input logic [31:0] d);
      i_ext_irq_host.wr_reg(a, s, d, ok);
      if (!ok) begin
         n_mismatch++;
         test_done;
      end
   endtask
   task automatic rc(input string what, input logic [7:0] a, input logic [1:0] s,
                     input logic [31:0] exp);
      i_ext_irq_host.rd_reg(a, s, v);
      chk(what, exp, v);
   endtask
   // poll until the pending bit drops, bounded
   task automatic wait_sync;
      int n;
      n = 0;
      do begin
         i_ext_irq_host.rd_reg(8'h00, 2'h2, v);
         n++;
      end while (v[15] !== 1'b0 && n < 20);
      if (v[15] !== 1'b0) begin
         n_mismatch++;
         test_done;
      end
   endtask
   task automatic pin0(input logic b);
      @(posedge clock_in);
      pins[0] <= b;
      repeat (6) @(posedge clock_in);
   endtask
   task automatic flag0(input bit clr, output logic f);
      if (clr) w(8'h10, 2'h1, 32'hffff);
      i_ext_irq_host.rd_reg(8'h10, 2'h2, v);
      f = v[0];
   endtask

   // random source and sense expectations {rise, high held, fall, low held}
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [3:0] exp_hits(input int c);
      case (c)
         1: return 4'b1000;
         2: return 4'b0010;
         3: return 4'b1010;
         4: return 4'b1110;
         5: return 4'b1011;
         default: return 4'b0000;
      endcase
   endfunction

   // main sequence
   initial begin
      nrst_in = 1'b0;
      sleeping_in = 1'b0;
      nmi_pin_in = 1'b0;
      pins = 16'h0;
      rnd = 32'd23;
      repeat (12) @(posedge clock_in);
      nrst_in <= 1'b1;
      w(8'h20, 2'h2, 32'hffffffff);
      for (int a = 0; a < 36; a += 4) rc("reset value", 8'(a), 2'h2, 32'h0);
      $display("test reset done");
      rnd = xs(rnd);
      w(8'h18, 2'h2, rnd);
      w(8'h1a, 2'h0, 32'h00a50000);
      rc("cfg half", 8'h1a, 2'h1, {rnd[31:24], 8'ha5, 16'h0});
      rc("cfg word", 8'h18, 2'h2, {rnd[31:24], 8'ha5, rnd[15:0]});
      rnd = xs(rnd);
      w(8'h1c, 2'h2, rnd);
      rc("cfg byte", 8'h1d, 2'h0, {16'h0, rnd[15:8], 8'h0});
      $display("test subword done");
      // interrupt enable goes in before wake enable
      w(8'h0c, 2'h1, 32'h1);
      w(8'h14, 2'h2, 32'h1);
      w(8'h04, 2'h0, 32'h1);
      // sense codes 0 to 5 (none to low), unfiltered then filtered; reserved 6 and 7 not driven
      for (int i = 0; i < 12; i++) begin
         w(8'h00, 2'h0, 32'h0);
         wait_sync;
         w(8'h18, 2'h0, {28'h0, i >= 6, 3'(i % 6)});
         w(8'h00, 2'h0, 32'h2);
         w(8'h00, 2'h0, 32'h2);
         rc("pending", 8'h00, 2'h2, 32'h00008002);
         wait_sync;
         w(8'h10, 2'h1, 32'hffff);
         pin0(1'b1);
         flag0(1'b0, got[3]);
         flag0(1'b1, got[2]);
         pin0(1'b0);
         flag0(1'b0, got[1]);
         flag0(1'b1, got[0]);
         chk("sense hits", {28'h0, exp_hits(i % 6)}, {28'h0, got});
      end
      $display("test sense done");
      @(posedge clock_in);
      sleeping_in <= 1'b1;
      @(negedge clock_in);
      chk("irq line", 32'h1, {16'h0, irq_out});
      chk("event", 32'h1, {16'h0, event_out});
      chk("wake", 32'h1, {31'h0, wake});
      w(8'h14, 2'h2, 32'hffff);
      rc("protected", 8'h14, 2'h2, 32'h1);
      w(8'h08, 2'h2, 32'hffff);
      @(negedge clock_in);
      chk("irq off", 32'h0, {16'h0, irq_out});
      chk("wake off", 32'h0, {31'h0, wake});
      $display("test outputs done");
      w(8'h02, 2'h0, 32'h00040000);
      @(posedge clock_in);
      nmi_pin_in <= 1'b1;
      w(8'h02, 2'h0, 32'h0);
      @(posedge clock_in);
      nmi_pin_in <= 1'b0;
      w(8'h03, 2'h0, 32'h0);
      @(negedge clock_in);
      chk("nmi kept", 32'h1, {31'h0, nmi_irq});
      w(8'h03, 2'h0, 32'h01000000);
      @(negedge clock_in);
      chk("nmi cleared", 32'h0, {31'h0, nmi_irq});
      $display("test nmi done");
      w(8'h00, 2'h0, 32'h3);
      // enable keeps its old one: the reset write's own enable bit is discarded
      rc("reset start", 8'h00, 2'h2, 32'h00008003);
      wait_sync;
      rc("reset end", 8'h00, 2'h2, 32'h0);
      rc("wake cleared", 8'h14, 2'h2, 32'h0);
      rc("cfg cleared", 8'h18, 2'h2, 32'h0);
      $display("test soft reset done");
      test_done;
   end
endmodule

bind external_irq_sync_wake ext_irq_asserts #(.SYNC_CYCLES(SYNC_CYCLES)) i_ext_irq_asserts (
   .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in), .size_in(size_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .ready_out(ready_out), .irq_out(irq_out), .sleeping_in(sleeping_in), .wake_out(wake_out));
